// >>> opmrs_regs.vh
`ifndef OPMRS_REGS_VH
`define OPMRS_REGS_VH

// Core clock rate
`define OPMRS_CLK_MHZ 50

// Register offsets
`define OPMRS_ADDR_OSC 4'h0
`define OPMRS_ADDR_STATUS 4'h1
`define OPMRS_ADDR_CONFIG 4'h2
`define OPMRS_ADDR_STATE 4'h3

// Oscillator control register fields
`define OPMRS_OSC_SEL_BIT 0
`define OPMRS_OSC_STOP_BIT 1
`define OPMRS_OSC_MODE_LSB 2
`define OPMRS_OSC_MODE_MSB 3
`define OPMRS_OSC_LCK_BIT 4
`define OPMRS_OSC_RESET 8'h01

// Operating mode field codes
`define OPMRS_MODE_RUN 2'h0
`define OPMRS_MODE_HALT 2'h1
`define OPMRS_MODE_STANDBY 2'h2

// Status register fields
`define OPMRS_ST_PD_BIT 3
`define OPMRS_ST_TO_BIT 4
`define OPMRS_ST_GIE_BIT 7

// Configuration register fields
`define OPMRS_CFG_STARTUP_BIT 0
`define OPMRS_CFG_PWR_LSB 1
`define OPMRS_CFG_PWR_MSB 3
`define OPMRS_CFG_DIV4_BIT 4
`define OPMRS_CFG_T0SRC_BIT 5
`define OPMRS_CFG_WDTRST_BIT 6
`define OPMRS_CFG_RESET 8'h41

// Power-up wait times in microseconds
`define OPMRS_PWR_T0_US 140
`define OPMRS_PWR_T1_US 4500
`define OPMRS_PWR_T2_US 18000
`define OPMRS_PWR_T3_US 72000
`define OPMRS_PWR_T4_US 288000

// Oscillator period counts
`define OPMRS_OST_PERIODS 5'h10
`define OPMRS_HALT_STAB_PERIODS 5'h10

// Wake-up
`define OPMRS_IRQ_VECTOR 11'h008
`define OPMRS_STBY_WAKE_MASK 8'hff
`define OPMRS_HALT_WAKE_MASK 8'hdc

`endif

// >>> opmrs_sync.v
`timescale 1ns/10ps
`default_nettype none

module opmrs_sync #(
   parameter W = 1
) (
   input wire clk,
   input wire rst_n,
   input wire [W-1:0] d,
   output reg [W-1:0] q
);

   reg [W-1:0] meta_r;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= {W{1'b0}};
         q <= {W{1'b0}};
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule

`default_nettype wire

// >>> opmrs_count.v
`timescale 1ns/10ps
`default_nettype none

module opmrs_count #(
   parameter W = 8
) (
   input wire clk,
   input wire rst_n,
   input wire load,
   input wire [W-1:0] load_val,
   input wire step,
   output wire done
);

   reg [W-1:0] cnt_r;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= {W{1'b0}};
      end else if (load) begin
         cnt_r <= load_val;
      end else if (step && (cnt_r != {W{1'b0}})) begin
         cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      end
   end

   assign done = (cnt_r == {W{1'b0}});

endmodule

`default_nettype wire

// >>> opmrs_top.v
// Operation
// - Reset completion enters normal or slow per config
// - Select bit chooses high or low oscillator
// - High oscillator stops only by stop bit or halt
// - Mode field 10b standby, 01b halt
// - Low clock routed to timer0 in normal
// - Halt entry: power-down clear, timeout set, watchdog clear
// - Standby stops execution, timers and modules follow enables
// - Halt disables oscillators, execution, timers, peripherals
// - Standby wakes on eight interrupt sources
// - Halt wakes on five listed sources only
// - Wake resumes normal or slow per select bit
// - Halt wake waits 16 oscillator periods
// - Wake branches to 0x008 when interrupts enabled
// - Reset on power-on, low voltage, pin, watchdog
// - Reset loads defined initial register values
// - Power-on, low-voltage, pin-from-halt flag effects
// - Watchdog reset flag effects depend on halt
// - Power-up wait from three-bit selection
// - Then 16 oscillator cycles start-up count
// - Stop bit and halt in one write
// - Interrupt enable set and cleared by instructions
// - Instruction clock is oscillator over 2 or 4
`include "opmrs_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module opmrs_top #(
   parameter [31:0] PWRUP_CYC_0 = `OPMRS_PWR_T0_US * `OPMRS_CLK_MHZ,
   parameter [31:0] PWRUP_CYC_1 = `OPMRS_PWR_T1_US * `OPMRS_CLK_MHZ,
   parameter [31:0] PWRUP_CYC_2 = `OPMRS_PWR_T2_US * `OPMRS_CLK_MHZ,
   parameter [31:0] PWRUP_CYC_3 = `OPMRS_PWR_T3_US * `OPMRS_CLK_MHZ,
   parameter [31:0] PWRUP_CYC_4 = `OPMRS_PWR_T4_US * `OPMRS_CLK_MHZ
) (
   // Clock and reset
   input wire I_CORE_CLK,
   input wire I_RESET_N,
   // Register port
   input wire [3:0] I_ADDR,
   input wire [7:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   output reg [7:0] O_RDATA,
   // Reset events
   input wire I_POR_EVENT,
   input wire I_LOW_VOLTAGE_RESET_EVENT,
   input wire I_RESET_PIN_N,
   input wire I_WDT_TIMEOUT,
   // Running system oscillator and wake sources
   input wire I_SYS_OSC,
   input wire [7:0] I_WAKE_SRC,
   // Instruction strobes
   input wire I_SLEEP_INSTR,
   input wire I_WATCHDOG_CLEAR_INSTRUCTION,
   input wire I_IRQ_ON_INSTRUCTION,
   input wire I_IRQ_OFF_INSTRUCTION,
   // Clock and gating controls
   output reg O_HIGH_OSC_EN,
   output reg O_LOW_OSC_EN,
   output reg O_SYS_CLK_HIGH,
   output reg O_INST_DIV4,
   output reg O_LOW_CLOCK_TO_TIMER0,
   output reg O_EXEC_EN,
   output reg O_TIMER_EN,
   output reg O_PERIPH_EN,
   output reg O_CPU_RESET_N,
   // Status and wake outputs
   output reg O_GLOBAL_IRQ_ENABLE,
   output reg O_WDT_CLEAR,
   output reg O_WAKE_BRANCH,
   output reg O_WAKE_CONTINUE,
   output reg [10:0] O_BRANCH_ADDR
);

   localparam ST_RESET = 3'h0;
   localparam ST_PWRUP = 3'h1;
   localparam ST_OST = 3'h2;
   localparam ST_RUN = 3'h3;
   localparam ST_STANDBY = 3'h4;
   localparam ST_HALT = 3'h5;
   localparam ST_STAB = 3'h6;

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [7:0] osc_control_reg_r;
   reg [7:0] config_r;
   reg timeout_flag_r;
   reg power_down_flag_r;
   reg global_irq_enable_r;
   reg fosc_d_r;
   reg pwr_load;
   reg osc_load;
   reg [23:0] pwr_cycles;
   wire [10:0] sync_q;
   wire [7:0] wake_s;
   wire por_s;
   wire lvr_s;
   wire pin_low_s;
   wire fosc_s;
   wire wdt_rst;
   wire evt_any;
   wire in_halt;
   wire pwr_done;
   wire osc_done;
   wire fosc_edge;
   wire osc_wr;
   wire [1:0] mode_wr;
   wire halt_req;
   wire stby_req;
   wire wake_stby;
   wire wake_halt;
   wire wake_now;

   opmrs_sync #(
      .W(11)
   ) u_sync (
      .clk(I_CORE_CLK),
      .rst_n(I_RESET_N),
      .d({I_WAKE_SRC, I_POR_EVENT, I_LOW_VOLTAGE_RESET_EVENT, ~I_RESET_PIN_N}),
      .q(sync_q)
   );

   opmrs_sync #(
      .W(1)
   ) u_sync_osc (
      .clk(I_CORE_CLK),
      .rst_n(I_RESET_N),
      .d(I_SYS_OSC),
      .q(fosc_s)
   );

   assign wake_s = sync_q[10:3];
   assign por_s = sync_q[2];
   assign lvr_s = sync_q[1];
   assign pin_low_s = sync_q[0];

   assign wdt_rst = I_WDT_TIMEOUT & config_r[`OPMRS_CFG_WDTRST_BIT];
   assign evt_any = por_s | lvr_s | pin_low_s | wdt_rst;
   assign in_halt = (state_r == ST_HALT) || (state_r == ST_STAB);

   assign fosc_edge = fosc_s & ~fosc_d_r;

   assign osc_wr = I_WR && (I_ADDR == `OPMRS_ADDR_OSC);
   assign mode_wr = I_WDATA[`OPMRS_OSC_MODE_MSB:`OPMRS_OSC_MODE_LSB];
   assign halt_req = I_SLEEP_INSTR || (osc_wr && (mode_wr == `OPMRS_MODE_HALT));
   assign stby_req = osc_wr && (mode_wr == `OPMRS_MODE_STANDBY);

   assign wake_stby = |(wake_s & `OPMRS_STBY_WAKE_MASK);
   assign wake_halt = |(wake_s & `OPMRS_HALT_WAKE_MASK);
   assign wake_now = ((state_r == ST_STANDBY) && wake_stby) ||
                     ((state_r == ST_STAB) && osc_done);

   always @* begin
      case (config_r[`OPMRS_CFG_PWR_MSB:`OPMRS_CFG_PWR_LSB])
         3'h0: pwr_cycles = PWRUP_CYC_0[23:0];
         3'h1: pwr_cycles = PWRUP_CYC_1[23:0];
         3'h2: pwr_cycles = PWRUP_CYC_2[23:0];
         3'h3: pwr_cycles = PWRUP_CYC_3[23:0];
         default: pwr_cycles = PWRUP_CYC_4[23:0];
      endcase
   end

   opmrs_count #(
      .W(24)
   ) u_pwr_cnt (
      .clk(I_CORE_CLK),
      .rst_n(I_RESET_N),
      .load(pwr_load),
      .load_val(pwr_cycles),
      .step(1'b1),
      .done(pwr_done)
   );

   // oscillator periods counted on the synchronised clock edges
   opmrs_count #(
      .W(5)
   ) u_osc_cnt (
      .clk(I_CORE_CLK),
      .rst_n(I_RESET_N),
      .load(osc_load),
      .load_val(state_r == ST_HALT ? `OPMRS_HALT_STAB_PERIODS : `OPMRS_OST_PERIODS),
      .step(fosc_edge),
      .done(osc_done)
   );

   always @* begin
      state_nxt = state_r;
      pwr_load = 1'b0;
      osc_load = 1'b0;
      case (state_r)
         ST_RESET: begin
            if (!evt_any) begin
               state_nxt = ST_PWRUP;
               pwr_load = 1'b1;
            end
         end
         ST_PWRUP: begin
            if (pwr_done) begin
               state_nxt = ST_OST;
               osc_load = 1'b1;
            end
         end
         ST_OST: begin
            if (osc_done) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            // halt takes precedence, stop bit stored alongside
            if (halt_req) begin
               state_nxt = ST_HALT;
            end else if (stby_req) begin
               state_nxt = ST_STANDBY;
            end
         end
         ST_STANDBY: begin
            if (wake_stby) begin
               state_nxt = ST_RUN;
            end
         end
         ST_HALT: begin
            if (wake_halt) begin
               state_nxt = ST_STAB;
               osc_load = 1'b1;
            end
         end
         ST_STAB: begin
            if (osc_done) begin
               state_nxt = ST_RUN;
            end
         end
         default: begin
            state_nxt = ST_RESET;
         end
      endcase
      if (evt_any) begin
         state_nxt = ST_RESET;
         pwr_load = 1'b0;
         osc_load = 1'b0;
      end
   end

   always @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         state_r <= ST_RESET;
         fosc_d_r <= 1'b0;
         osc_control_reg_r <= `OPMRS_OSC_RESET;
         config_r <= `OPMRS_CFG_RESET;
         timeout_flag_r <= 1'b1;
         power_down_flag_r <= 1'b1;
         global_irq_enable_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         fosc_d_r <= fosc_s;
         if (I_WR && (I_ADDR == `OPMRS_ADDR_CONFIG)) begin
            config_r <= I_WDATA;
         end
         if (evt_any) begin
            osc_control_reg_r <= `OPMRS_OSC_RESET;
            global_irq_enable_r <= 1'b0;
            if (state_r != ST_RESET) begin
               if (por_s || lvr_s) begin
                  timeout_flag_r <= 1'b1;
                  power_down_flag_r <= 1'b1;
               end else if (pin_low_s) begin
                  // pin reset only changes flags from halt
                  if (in_halt) begin
                     timeout_flag_r <= 1'b1;
                     power_down_flag_r <= 1'b1;
                  end
               end else begin
                  timeout_flag_r <= 1'b0;
                  power_down_flag_r <= !in_halt;
               end
            end
         end else begin
            if ((state_r == ST_OST) && osc_done) begin
               osc_control_reg_r[`OPMRS_OSC_SEL_BIT] <= config_r[`OPMRS_CFG_STARTUP_BIT];
            end else if ((state_r == ST_RUN) && osc_wr) begin
               // select and stop bits under software control
               osc_control_reg_r <= {3'h0, I_WDATA[`OPMRS_OSC_LCK_BIT],
                                     (halt_req || stby_req) ? mode_wr : `OPMRS_MODE_RUN,
                                     I_WDATA[`OPMRS_OSC_STOP_BIT], I_WDATA[`OPMRS_OSC_SEL_BIT]};
            end else if ((state_r == ST_RUN) && I_SLEEP_INSTR) begin
               osc_control_reg_r[`OPMRS_OSC_MODE_MSB:`OPMRS_OSC_MODE_LSB] <= `OPMRS_MODE_HALT;
            end else if (wake_now) begin
               osc_control_reg_r[`OPMRS_OSC_MODE_MSB:`OPMRS_OSC_MODE_LSB] <= `OPMRS_MODE_RUN;
            end
            if ((state_r == ST_RUN) && halt_req) begin
               timeout_flag_r <= 1'b1;
               power_down_flag_r <= 1'b0;
            end else if ((state_r == ST_RUN) && I_WATCHDOG_CLEAR_INSTRUCTION) begin
               timeout_flag_r <= 1'b1;
               power_down_flag_r <= 1'b1;
            end
            if (I_IRQ_ON_INSTRUCTION) begin
               global_irq_enable_r <= 1'b1;
            end else if (I_IRQ_OFF_INSTRUCTION) begin
               global_irq_enable_r <= 1'b0;
            end
         end
      end
   end

   // Registered outputs follow the current state one cycle later
   always @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_RDATA <= 8'h00;
         O_HIGH_OSC_EN <= 1'b1;
         O_LOW_OSC_EN <= 1'b1;
         O_SYS_CLK_HIGH <= 1'b1;
         O_INST_DIV4 <= 1'b0;
         O_LOW_CLOCK_TO_TIMER0 <= 1'b0;
         O_EXEC_EN <= 1'b0;
         O_TIMER_EN <= 1'b0;
         O_PERIPH_EN <= 1'b0;
         O_CPU_RESET_N <= 1'b0;
         O_GLOBAL_IRQ_ENABLE <= 1'b0;
         O_WDT_CLEAR <= 1'b0;
         O_WAKE_BRANCH <= 1'b0;
         O_WAKE_CONTINUE <= 1'b0;
         O_BRANCH_ADDR <= 11'h000;
      end else begin
         O_RDATA <= 8'h00;
         if (I_RD) begin
            case (I_ADDR)
               `OPMRS_ADDR_OSC: O_RDATA <= osc_control_reg_r;
               `OPMRS_ADDR_STATUS: O_RDATA <= {global_irq_enable_r, 2'h0, timeout_flag_r,
                                               power_down_flag_r, 3'h0};
               `OPMRS_ADDR_CONFIG: O_RDATA <= config_r;
               `OPMRS_ADDR_STATE: O_RDATA <= {5'h00, state_r};
               default: O_RDATA <= 8'h00;
            endcase
         end
         // high oscillator stops only on stop bit or in halt
         // stop while selected is software's hazard
         O_HIGH_OSC_EN <= !osc_control_reg_r[`OPMRS_OSC_STOP_BIT] && (state_r != ST_HALT);
         O_LOW_OSC_EN <= (state_r != ST_HALT);
         O_SYS_CLK_HIGH <= osc_control_reg_r[`OPMRS_OSC_SEL_BIT];
         O_INST_DIV4 <= config_r[`OPMRS_CFG_DIV4_BIT];
         // low clock to timer0 in normal mode
         O_LOW_CLOCK_TO_TIMER0 <= (state_r == ST_RUN) && osc_control_reg_r[`OPMRS_OSC_SEL_BIT] &&
                                  osc_control_reg_r[`OPMRS_OSC_LCK_BIT] && config_r[`OPMRS_CFG_T0SRC_BIT];
         O_EXEC_EN <= (state_r == ST_RUN);
         O_TIMER_EN <= (state_r == ST_RUN) || (state_r == ST_STANDBY);
         O_PERIPH_EN <= (state_r == ST_RUN) || (state_r == ST_STANDBY);
         O_CPU_RESET_N <= (state_r != ST_RESET) && (state_r != ST_PWRUP) && (state_r != ST_OST);
         O_GLOBAL_IRQ_ENABLE <= global_irq_enable_r;
         O_WDT_CLEAR <= !evt_any && (state_r == ST_RUN) && (halt_req || I_WATCHDOG_CLEAR_INSTRUCTION);
         // vector on wake with interrupts on
         O_WAKE_BRANCH <= !evt_any && wake_now && global_irq_enable_r;
         O_WAKE_CONTINUE <= !evt_any && wake_now && !global_irq_enable_r;
         if (!evt_any && wake_now && global_irq_enable_r) begin
            O_BRANCH_ADDR <= `OPMRS_IRQ_VECTOR;
         end
      end
   end

endmodule

`default_nettype wire

// >>> opmrs_chk.sv
`timescale 1ns/10ps
`default_nettype none
module opmrs_chk (
   // Clock, reset and register port
   input wire logic I_CORE_CLK,
   input wire logic I_RESET_N,
   input wire logic [3:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   input wire logic [7:0] O_RDATA,
   // Instructions and gating
   input wire logic I_SLEEP_INSTR,
   input wire logic O_HIGH_OSC_EN,
   input wire logic O_LOW_OSC_EN,
   input wire logic O_SYS_CLK_HIGH,
   input wire logic O_EXEC_EN,
   input wire logic O_TIMER_EN,
   input wire logic O_PERIPH_EN,
   input wire logic O_CPU_RESET_N,
   // Wake outputs
   input wire logic O_WDT_CLEAR,
   input wire logic O_WAKE_BRANCH,
   input wire logic O_WAKE_CONTINUE,
   input wire logic [10:0] O_BRANCH_ADDR
);
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (!I_RESET_N);
   // Plain oscillator write while running
   sequence s_osc_wr;
      I_WR && I_ADDR == 4'h0 && O_EXEC_EN && I_WDATA[3:2] == 2'h0;
   endsequence
   sequence s_sleep;
      I_SLEEP_INSTR && O_EXEC_EN;
   endsequence
   // Watchdog clear pulse first, gating one cycle behind it
   sequence s_halt_resp;
      O_WDT_CLEAR ##1 (!O_LOW_OSC_EN && !O_HIGH_OSC_EN && !O_EXEC_EN);
   endsequence
   a_rdata_idle: assert property (!I_RD |=> O_RDATA == 8'h00)
      else $error("read data not zero outside read slot");
   a_select_osc: assert property (s_osc_wr |-> ##2 O_SYS_CLK_HIGH == $past(I_WDATA[0], 2))
      else $error("system clock select does not follow write");
   a_stop_high: assert property (s_osc_wr ##0 I_WDATA[1] |-> ##2 !O_HIGH_OSC_EN)
      else $error("high oscillator not stopped");
   a_keep_high: assert property (s_osc_wr ##0 !I_WDATA[1] |-> ##2 O_HIGH_OSC_EN)
      else $error("high oscillator stopped without stop bit");
   a_halt_entry: assert property (s_sleep |-> ##1 s_halt_resp)
      else $error("halt entry outputs wrong");
   a_halt_gate: assert property (!O_LOW_OSC_EN |-> !O_EXEC_EN && !O_TIMER_EN && !O_PERIPH_EN)
      else $error("activity while oscillators off");
   a_wake_excl: assert property (!(O_WAKE_BRANCH && O_WAKE_CONTINUE))
      else $error("branch and continue together");
   a_branch_addr: assert property (O_WAKE_BRANCH |-> ##1 O_BRANCH_ADDR == 11'h008)
      else $error("branch address wrong");
   a_reset_hold: assert property ($rose(I_RESET_N) |-> !O_CPU_RESET_N [*8])
      else $error("cpu released too early");
   a_exec_cpu: assert property (O_EXEC_EN |-> O_CPU_RESET_N)
      else $error("execution during reset");
endmodule
bind opmrs_top opmrs_chk opmrs_chk_inst (.*);
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic I_CORE_CLK = 0;
   logic I_RESET_N = 0;
   logic I_WR = 0;
   logic I_RD = 0;
   logic I_POR_EVENT = 0;
   logic I_LOW_VOLTAGE_RESET_EVENT = 0;
   logic I_RESET_PIN_N = 1;
   logic I_WDT_TIMEOUT = 0;
   logic I_SYS_OSC = 0;
   logic [3:0] I_ADDR = 0;
   logic [7:0] I_WDATA = 0;
   logic [7:0] I_WAKE_SRC = 0;
   logic [3:0] pls = 0;
   wire I_SLEEP_INSTR = pls[0];
   wire I_WATCHDOG_CLEAR_INSTRUCTION = pls[1];
   wire I_IRQ_ON_INSTRUCTION = pls[2];
   wire I_IRQ_OFF_INSTRUCTION = pls[3];
   logic [7:0] O_RDATA;
   logic O_HIGH_OSC_EN, O_LOW_OSC_EN, O_SYS_CLK_HIGH, O_INST_DIV4, O_LOW_CLOCK_TO_TIMER0, O_EXEC_EN;
   logic O_TIMER_EN, O_PERIPH_EN, O_CPU_RESET_N, O_GLOBAL_IRQ_ENABLE, O_WDT_CLEAR, O_WAKE_BRANCH;
   logic O_WAKE_CONTINUE;
   logic [10:0] O_BRANCH_ADDR;
   int n_mismatch = 0;
   int compares = 0;
   int cyc = 0;
   int nbr = 0;
   int nct = 0;
   int pw[5] = '{20, 30, 40, 50, 60};
   int kd[6] = '{0, 3, 1, 3, 0, 2};
   logic [5:0] hl = 6'b011000;
   logic [7:0] stx[6] = '{8'h10, 8'h08, 8'h18, 8'h00, 8'h18, 8'h18};
   logic [7:0] q[$];
   logic rd_d = 0;

   opmrs_top #(.PWRUP_CYC_0(20), .PWRUP_CYC_1(30), .PWRUP_CYC_2(40), .PWRUP_CYC_3(50),
      .PWRUP_CYC_4(60)) opmrs_top_inst (.*);

   initial forever #10 I_CORE_CLK = ~I_CORE_CLK;

   // Oscillator at a quarter of the core rate, wake counters, hang guard
   always @(posedge I_CORE_CLK) begin
      cyc <= cyc + 1;
      if (cyc[0])
         I_SYS_OSC <= ~I_SYS_OSC;
      nbr <= nbr + (O_WAKE_BRANCH === 1'b1);
      nct <= nct + (O_WAKE_CONTINUE === 1'b1);
      rd_d <= I_RD;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude;
      end
   end

   always @(negedge I_CORE_CLK)
      if (rd_d)
         chk("rdata", q.pop_front(), O_RDATA);

   task conclude;
      if (n_mismatch == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task chk(string nm, logic [10:0] e, logic [10:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   task clk1(int n);
      repeat (n) @(posedge I_CORE_CLK);
   endtask

   task wr(logic [3:0] a, logic [7:0] d);
      @(posedge I_CORE_CLK);
      I_WR <= 1;
      I_ADDR <= a;
      I_WDATA <= d;
      @(posedge I_CORE_CLK);
      I_WR <= 0;
   endtask

   task rd(logic [3:0] a, logic [7:0] e);
      @(posedge I_CORE_CLK);
      I_RD <= 1;
      I_ADDR <= a;
      q.push_back(e);
      @(posedge I_CORE_CLK);
      I_RD <= 0;
   endtask

   task pul(int k);
      @(posedge I_CORE_CLK);
      pls[k] <= 1;
      @(posedge I_CORE_CLK);
      pls <= 0;
   endtask

   task run_wait(int lim, output int n);
      n = 0;
      do begin
         @(negedge I_CORE_CLK);
         n++;
      end while (O_EXEC_EN !== 1'b1 && n < lim);
   endtask

   task rev(int k, int sl, int g, logic [7:0] stat);
      int n;
      @(posedge I_CORE_CLK);
      case (k)
         0: I_RESET_PIN_N <= 0;
         1: I_LOW_VOLTAGE_RESET_EVENT <= 1;
         2: I_POR_EVENT <= 1;
         default: I_WDT_TIMEOUT <= 1;
      endcase
      clk1(k == 3 ? 1 : 6);
      {I_RESET_PIN_N, I_LOW_VOLTAGE_RESET_EVENT, I_POR_EVENT, I_WDT_TIMEOUT} <= 4'h8;
      // A one-cycle watchdog event needs two edges to drop the gating outputs
      clk1(2);
      chk("cpurst", 0, O_CPU_RESET_N);
      run_wait(400, n);
      chk("wait", n >= pw[sl] + 60 && n <= pw[sl] + 72, 1);
      chk("sysclk", g, O_SYS_CLK_HIGH);
      rd(4'h1, stat);
      rd(4'h2, 8'(8'h40 | (sl << 1) | g));
      rd(4'h0, 8'(g));
   endtask

   initial begin
      int n, b, g, sl, b0, c0;
      n = $urandom(96);
      clk1(16);
      I_RESET_N <= 1;
      run_wait(400, n);
      chk("wait", n >= 80 && n <= 92, 1);
      rd(4'h2, 8'h41);
      rd(4'h1, 8'h18);
      rd(4'h0, 8'h01);
      rd(4'h3, 8'h03);
      rd(4'h9, 8'h00);
      wr(4'h1, 8'hff);
      rd(4'h1, 8'h18);
      wr(4'h0, 8'h00);
      clk1(2);
      chk("sysclk", 0, O_SYS_CLK_HIGH);
      chk("hosc", 1, O_HIGH_OSC_EN);
      wr(4'h0, 8'h02);
      clk1(2);
      chk("hosc", 0, O_HIGH_OSC_EN);
      wr(4'h0, 8'h11);
      wr(4'h2, 8'h71);
      clk1(2);
      chk("sysclk", 1, O_SYS_CLK_HIGH);
      chk("lck", 1, O_LOW_CLOCK_TO_TIMER0);
      chk("div4", 1, O_INST_DIV4);
      wr(4'h2, 8'h41);
      clk1(2);
      chk("lck", 0, O_LOW_CLOCK_TO_TIMER0);
      pul(2);
      clk1(2);
      chk("gie", 1, O_GLOBAL_IRQ_ENABLE);
      rd(4'h1, 8'h98);
      pul(3);
      clk1(2);
      chk("gie", 0, O_GLOBAL_IRQ_ENABLE);
      for (b = 0; b < 16; b++) begin
         g = $urandom % 2;
         sl = $urandom % 2;
         pul(g ? 2 : 3);
         wr(4'h0, 8'(sl));
         b0 = nbr;
         c0 = nct;
         if (b < 8)
            wr(4'h0, 8'(8'h08 | sl));
         else if (b[0])
            pul(0);
         else
            wr(4'h0, 8'(8'h04 | (sl ? 0 : 2) | sl));
         clk1(3);
         chk("exec", 0, O_EXEC_EN);
         chk("losc", b < 8, O_LOW_OSC_EN);
         chk("timer", b < 8, O_TIMER_EN);
         chk("periph", b < 8, O_PERIPH_EN);
         chk("hosc", b < 8, O_HIGH_OSC_EN);
         if (b < 8)
            rd(4'h3, 8'h04);
         else
            rd(4'h1, g ? 8'h90 : 8'h10);
         if (b >= 8 && ((8'hdc >> (b - 8)) & 8'h01) == 0) begin
            I_WAKE_SRC <= 8'(1 << (b - 8));
            clk1(12);
            chk("exec", 0, O_EXEC_EN);
            rd(4'h3, 8'h05);
            I_WAKE_SRC <= 8'h04;
         end else
            I_WAKE_SRC <= 8'(1 << (b % 8));
         run_wait(200, n);
         chk("wake", b < 8 ? n <= 8 : n >= 60 && n <= 80, 1);
         I_WAKE_SRC <= 0;
         clk1(2);
         chk("branch", g, nbr - b0);
         chk("cont", !g, nct - c0);
         if (g)
            chk("vector", 11'h008, O_BRANCH_ADDR);
         chk("sysclk", sl, O_SYS_CLK_HIGH);
         chk("hosc", (b >= 8 && !b[0]) ? sl : 1, O_HIGH_OSC_EN);
      end
      pul(3);
      for (b = 0; b < 6; b++) begin
         sl = $urandom % 5;
         g = $urandom % 2;
         wr(4'h2, 8'(8'h40 | (sl << 1) | g));
         if (hl[b]) begin
            pul(0);
            clk1(3);
         end
         rev(kd[b], sl, g, stx[b]);
         if (b == 1) begin
            pul(1);
            rd(4'h1, 8'h18);
         end
      end
      clk1(4);
      conclude;
   end
endmodule
`default_nettype wire
